// ==== core/padc_pkg.sv ====
// Package for the upper port A direction control block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package padc_pkg;

    // Register map
    localparam logic [7:0]  DIR_REG_ADDR      = 8'h00;
    localparam logic [7:0]  FUNC_REG_ADDR     = 8'h04;
    localparam logic [7:0]  PIN_STATE_ADDR    = 8'h08;

    // Field layout and reset values
    localparam int          PIN_COUNT         = 10;
    localparam int          REG_WIDTH         = 16;
    localparam logic [15:0] DIR_RESET         = 16'h0000;
    localparam logic [9:0]  FUNC_GPIO_RESET   = 10'h3FF;

    // APB request as seen by the slave
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } padc_apb_req_t;

    // Whole state of the top module
    typedef struct packed {
        logic [9:0]  dir;
        logic [9:0]  gpio_sel;
        logic [31:0] rdata;
        logic        slverr;
    } padc_state_t;

endpackage

// ==== core/padc_pin_cell.sv ====
// One pad-side direction cell: mixes the port direction with the peripheral one.
// Assumes the pin function select comes from elsewhere in the pin controller.
`timescale 1ns/100ps
`default_nettype none
module padc_pin_cell (
    input  wire logic gpio_sel_in,
    input  wire logic dir_bit_in,
    input  wire logic periph_oe_n_in,
    output logic      pin_oe_n_out
);
    // Peripheral keeps its own direction when the pin is not general I/O
    assign pin_oe_n_out = gpio_sel_in ? ~dir_bit_in : periph_oe_n_in;

endmodule
`default_nettype wire

// ==== core/padc_top.sv ====
// Upper port A direction register with APB access and pin enables.
// Assumes an APB master in the CLK_IN domain and a pad ring outside.
//
// Contract
// - A 16-bit read/write register chooses direction for the upper port A pins.
// - Direction bit n drives pin n, bit nine being the top pin.
// - A direction bit acts only while its pin is in general I/O use.
// - A one in a direction bit of a general I/O pin makes the pin an output.
// - A zero in a direction bit of a general I/O pin leaves the pin undriven.
// - Bits fifteen to ten hold nothing and read as zero.
// - Reset clears the register, so every pin starts as an input.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module padc_top #(
    parameter int PINS = 10
) (
    input  wire logic              CLK_IN,
    input  wire logic              RST_N_IN,
    input  wire logic              PSEL_IN,
    input  wire logic              PENABLE_IN,
    input  wire logic              PWRITE_IN,
    input  wire logic [7:0]        PADDR_IN,
    input  wire logic [31:0]       PWDATA_IN,
    output logic      [31:0]       PRDATA_OUT,
    output logic                   PREADY_OUT,
    output logic                   PSLVERR_OUT,
    input  wire logic [PINS-1:0]   PERIPH_OE_N_IN,
    input  wire logic [PINS-1:0]   PIN_LEVEL_IN,
    output logic      [PINS-1:0]   PIN_OE_N_OUT,
    output logic      [PINS-1:0]   GPIO_SEL_OUT
);

    padc_pkg::padc_apb_req_t req;
    padc_pkg::padc_state_t   state_reg;
    padc_pkg::padc_state_t   state_next;
    logic                    access;
    logic [15:0]             dir_word;
    logic                    addr_hit;
    logic                    read_setup;

    // Bundle bus signals
    assign req.psel    = PSEL_IN;
    assign req.penable = PENABLE_IN;
    assign req.pwrite  = PWRITE_IN;
    assign req.paddr   = PADDR_IN;
    assign req.pwdata  = PWDATA_IN;

    // Zero wait states: every access completes in its first access cycle
    assign access     = req.psel & req.penable;
    assign PREADY_OUT = 1'b1;

    // Address and read-setup decode, used by the checks below
    assign addr_hit   = (req.paddr == padc_pkg::DIR_REG_ADDR)
                        || (req.paddr == padc_pkg::FUNC_REG_ADDR)
                        || (req.paddr == padc_pkg::PIN_STATE_ADDR);
    assign read_setup = req.psel & ~req.penable & ~req.pwrite;

    // Reserved bits are not stored, so they can only read back as zero
    assign dir_word = {6'h00, state_reg.dir};

    // Next-state and register decode
    always_comb
    begin
        state_next        = state_reg;
        state_next.slverr = 1'b0;
        if (access && req.pwrite)
        begin
            if (req.paddr == padc_pkg::DIR_REG_ADDR)
            begin
                // Upper write bits dropped; software should send zeros there
                state_next.dir = req.pwdata[9:0];
            end
            else if (req.paddr == padc_pkg::FUNC_REG_ADDR)
            begin
                state_next.gpio_sel = req.pwdata[9:0];
            end
            else if (req.paddr != padc_pkg::PIN_STATE_ADDR)
            begin
                state_next.slverr = 1'b1;
            end
        end
        else if (req.psel && !req.penable && !req.pwrite)
        begin
            // Setup cycle loads read data so it stands in the access cycle
            if (req.paddr == padc_pkg::DIR_REG_ADDR)
            begin
                state_next.rdata = {16'h0000, dir_word};
            end
            else if (req.paddr == padc_pkg::FUNC_REG_ADDR)
            begin
                state_next.rdata = {22'h000000, state_reg.gpio_sel};
            end
            else if (req.paddr == padc_pkg::PIN_STATE_ADDR)
            begin
                state_next.rdata = {22'h000000, PIN_LEVEL_IN};
            end
            else
            begin
                state_next.rdata = 32'h00000000;
            end
        end
        if (access && !req.pwrite && req.paddr != padc_pkg::DIR_REG_ADDR
            && req.paddr != padc_pkg::FUNC_REG_ADDR
            && req.paddr != padc_pkg::PIN_STATE_ADDR)
        begin
            state_next.slverr = 1'b1;
        end
    end

    // State register
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            state_reg.dir      <= padc_pkg::DIR_RESET[9:0];
            state_reg.gpio_sel <= padc_pkg::FUNC_GPIO_RESET;
            state_reg.rdata    <= 32'h00000000;
            state_reg.slverr   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Error is combinational so it pairs with the one-cycle access
    assign PSLVERR_OUT = access && (req.paddr != padc_pkg::DIR_REG_ADDR)
                         && (req.paddr != padc_pkg::FUNC_REG_ADDR)
                         && (req.paddr != padc_pkg::PIN_STATE_ADDR);
    assign PRDATA_OUT   = state_reg.rdata;
    assign GPIO_SEL_OUT = state_reg.gpio_sel;

    // One cell per pin, bit index equals pin index
    genvar i;
    generate
        for (i = 0; i < PINS; i++)
        begin : g_pin
            padc_pin_cell u_cell (
                .gpio_sel_in    (state_reg.gpio_sel[i]),
                .dir_bit_in     (state_reg.dir[i]),
                .periph_oe_n_in (PERIPH_OE_N_IN[i]),
                .pin_oe_n_out   (PIN_OE_N_OUT[i])
            );
        end
    endgenerate

    // Checks
    a_write_updates_dir: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        access && PWRITE_IN && PADDR_IN == padc_pkg::DIR_REG_ADDR
        |=> state_reg.dir == $past(PWDATA_IN[9:0]))
        else $error("direction write not stored");

    a_read_dir_value: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == padc_pkg::DIR_REG_ADDR
        |=> PRDATA_OUT[9:0] == $past(state_reg.dir))
        else $error("direction read wrong");

    a_reserved_read_zero: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == padc_pkg::DIR_REG_ADDR
        |=> PRDATA_OUT[31:10] == 22'h000000)
        else $error("reserved bits not zero");

    a_output_when_set: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (state_reg.gpio_sel & state_reg.dir) == ((state_reg.gpio_sel & ~PIN_OE_N_OUT)))
        else $error("gpio output not driven");

    a_input_when_clear: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (state_reg.gpio_sel & ~state_reg.dir) == (state_reg.gpio_sel & PIN_OE_N_OUT))
        else $error("gpio input driven");

    a_periph_passes: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (~state_reg.gpio_sel & PIN_OE_N_OUT) == (~state_reg.gpio_sel & PERIPH_OE_N_IN))
        else $error("peripheral direction overridden");

    a_reset_clears_dir: assert property (@(posedge CLK_IN)
        !RST_N_IN |=> state_reg.dir == 10'h000)
        else $error("reset left direction set");

    a_pin_map_top: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        state_reg.gpio_sel[PINS-1] |-> PIN_OE_N_OUT[PINS-1] == !state_reg.dir[PINS-1])
        else $error("top pin mapping wrong");

    a_select_mix: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $changed(state_reg.gpio_sel) |-> PIN_OE_N_OUT ==
            ((state_reg.gpio_sel & ~state_reg.dir) | (~state_reg.gpio_sel & PERIPH_OE_N_IN)))
        else $error("enable mix wrong");

    // Bus timing checks: zero wait, error only in a bad access cycle.
    // Read data is loaded at the setup edge and must then stand still,
    // since the master samples it one edge later.

    // Slave never stalls
    a_ready_high: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        1'b1 |-> PREADY_OUT)
        else $error("ready dropped");

    // Unmapped access flags an error
    a_err_unmapped: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        access && !addr_hit |-> PSLVERR_OUT)
        else $error("missing slave error");

    // No error outside a bad access
    a_err_quiet: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        !access || addr_hit |-> !PSLVERR_OUT)
        else $error("spurious slave error");

    // Registered error copy follows the bus error
    a_err_tracked: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        1'b1 |=> state_reg.slverr == $past(PSLVERR_OUT))
        else $error("error copy lost");

    // Read data stands until the next read setup
    a_rdata_stable: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        !read_setup |=> $stable(PRDATA_OUT))
        else $error("read data moved");

    // Unmapped read returns zero
    a_unmapped_rd_zero: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        read_setup && !addr_hit |=> PRDATA_OUT == 32'h00000000)
        else $error("unmapped read not zero");

    // Pin level read shows the pads at setup
    a_pin_read_value: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        read_setup && req.paddr == padc_pkg::PIN_STATE_ADDR
        |=> PRDATA_OUT[PINS-1:0] == $past(PIN_LEVEL_IN))
        else $error("pin level read wrong");

    // Select read returns the stored select
    a_sel_read_value: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        read_setup && req.paddr == padc_pkg::FUNC_REG_ADDR
        |=> PRDATA_OUT[9:0] == $past(state_reg.gpio_sel))
        else $error("select read wrong");

    // Select write lands in its access cycle
    a_func_write: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        access && req.pwrite && req.paddr == padc_pkg::FUNC_REG_ADDR
        |=> state_reg.gpio_sel == $past(PWDATA_IN[9:0]))
        else $error("select write not stored");

    // Select only moves on its own write
    a_sel_hold: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        !(access && req.pwrite && req.paddr == padc_pkg::FUNC_REG_ADDR)
        |=> $stable(state_reg.gpio_sel))
        else $error("select changed unasked");

    // Direction only moves on its own write
    a_dir_hold: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        !(access && req.pwrite && req.paddr == padc_pkg::DIR_REG_ADDR)
        |=> $stable(state_reg.dir))
        else $error("direction changed unasked");

    // Writes to a bad address touch nothing
    a_unmapped_keeps: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        access && req.pwrite && !addr_hit
        |=> $stable(state_reg.dir) && $stable(state_reg.gpio_sel))
        else $error("unmapped write stored");

    // Every pin is an input straight after reset
    a_reset_all_input: assert property (@(posedge CLK_IN)
        !RST_N_IN |=> PIN_OE_N_OUT == {PINS{1'b1}})
        else $error("pin driven after reset");

    // Read data cleared by reset
    a_reset_rdata: assert property (@(posedge CLK_IN)
        !RST_N_IN |=> PRDATA_OUT == 32'h00000000)
        else $error("read data not cleared");

    // Pins come out of reset as general I/O
    a_reset_sel: assert property (@(posedge CLK_IN)
        !RST_N_IN |=> state_reg.gpio_sel == padc_pkg::FUNC_GPIO_RESET)
        else $error("select not reset");

    // Bottom bit steers the bottom pin
    a_pin_map_bottom: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        state_reg.gpio_sel[0] |-> PIN_OE_N_OUT[0] == !state_reg.dir[0])
        else $error("bottom pin mapping wrong");

    // Top pin follows its peripheral when not general I/O
    a_top_pin_periph: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        !state_reg.gpio_sel[PINS-1] |-> PIN_OE_N_OUT[PINS-1] == PERIPH_OE_N_IN[PINS-1])
        else $error("top pin peripheral lost");

    c_dir_write: cover property (@(posedge CLK_IN)
        access && PWRITE_IN && PADDR_IN == padc_pkg::DIR_REG_ADDR);
    c_dir_read: cover property (@(posedge CLK_IN)
        access && !PWRITE_IN && PADDR_IN == padc_pkg::DIR_REG_ADDR);
    c_bad_addr: cover property (@(posedge CLK_IN) PSLVERR_OUT);
    c_periph_pin: cover property (@(posedge CLK_IN) RST_N_IN && !state_reg.gpio_sel[0]);
    c_pin_read: cover property (@(posedge CLK_IN)
        read_setup && req.paddr == padc_pkg::PIN_STATE_ADDR);

endmodule
`default_nettype wire

// ==== verification/padc_top_test.sv ====
// Bench for the upper port A direction block: APB master, pad drive, checks.
// Assumes padc_pkg and padc_top are compiled first; no partner model.
`timescale 1ns/100ps
`default_nettype none
module padc_top_test;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [9:0]  periph_oe_n = 10'h000;
    logic [9:0]  pin_level = 10'h000;
    logic [9:0]  pin_oe_n;
    logic [9:0]  gpio_sel;
    logic [31:0] rd;
    logic [9:0]  d;
    logic [9:0]  s;
    int          n_errors = 0;
    int          checks = 0;

    padc_top #(.PINS(10)) uut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .PERIPH_OE_N_IN(periph_oe_n), .PIN_LEVEL_IN(pin_level),
        .PIN_OE_N_OUT(pin_oe_n), .GPIO_SEL_OUT(gpio_sel));

    // 50 MHz clock
    always #10 clk = ~clk;

    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; last releases the bus, otherwise the next setup follows at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input bit last, output logic [31:0] rdv);
        int   n;
        logic unm;
        unm = !(a == padc_pkg::DIR_REG_ADDR || a == padc_pkg::FUNC_REG_ADDR ||
                a == padc_pkg::PIN_STATE_ADDR);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rdv = prdata;
        chk({31'h0, pready}, 32'h1);
        chk({31'h0, pslverr}, {31'h0, unm});
        if (last)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask

    // Pin enable expected from select, direction and peripheral enable
    function automatic logic [9:0] exp_oe(input logic [9:0] sel, dir, per);
        logic [9:0] r;
        for (int i = 0; i < 10; i++)
            r[i] = sel[i] ? ~dir[i] : per[i];
        return r;
    endfunction

    task automatic check_all(input logic [9:0] ed, input logic [9:0] es);
        apb(1'b0, padc_pkg::DIR_REG_ADDR, 32'h0, 1'b0, rd);
        chk(rd, {22'h0, ed});
        apb(1'b0, padc_pkg::FUNC_REG_ADDR, 32'h0, 1'b0, rd);
        chk(rd, {22'h0, es});
        apb(1'b0, padc_pkg::PIN_STATE_ADDR, 32'h0, 1'b1, rd);
        chk(rd, {22'h0, pin_level});
        chk({22'h0, gpio_sel}, {22'h0, es});
        chk({22'h0, pin_oe_n}, {22'h0, exp_oe(es, ed, periph_oe_n)});
    endtask

    // Peripherals all drive during reset, so undriven pins prove the cleared direction
    task automatic do_reset();
        rst_n <= 1'b0;
        periph_oe_n <= 10'h000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask

    initial
    begin
        void'($urandom(37));
        do_reset();
        check_all(10'h000, padc_pkg::FUNC_GPIO_RESET);
        for (int i = 0; i < 40; i++)
        begin
            d = (i < 2) ? 10'h3FF : 10'($urandom);
            s = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($urandom);
            periph_oe_n <= 10'($urandom);
            pin_level <= 10'($urandom);
            apb(1'b1, padc_pkg::DIR_REG_ADDR, {22'h0, d}, 1'b0, rd);
            apb(1'b1, padc_pkg::FUNC_REG_ADDR, {22'h0, s}, 1'b0, rd);
            // Pin level word is read-only: write is dropped without error
            apb(1'b1, padc_pkg::PIN_STATE_ADDR, $urandom, 1'b0, rd);
            // Unmapped write must leave everything alone
            apb(1'b1, {6'($urandom_range(63, 3)), 2'b00}, $urandom, 1'b0, rd);
            check_all(d, s);
        end
        apb(1'b0, 8'hFC, 32'h0, 1'b1, rd);
        chk(rd, 32'h0);
        // Second reset in mid-run
        do_reset();
        check_all(10'h000, padc_pkg::FUNC_GPIO_RESET);
        close_out();
    end

    // Watchdog, far beyond the roughly 600 cycles the run needs
    initial
    begin
        #(20 * 5000);
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
